/* rtl/era_pkg.sv */
// Constants for the receive alarm, status and counter block
`default_nettype none
package era_pkg;
  // Register indices on the plain register port
  localparam logic [7:0] ADDR_RSR = 8'h00;
  localparam logic [7:0] ADDR_FEC = 8'h01;
  localparam logic [7:0] ADDR_CVC = 8'h02;
  localparam logic [7:0] ADDR_CEC = 8'h03;
  localparam logic [7:0] ADDR_RSW = 8'h04;
  localparam logic [7:0] ADDR_RSP = 8'h05;
  localparam logic [7:0] ADDR_CNTX = 8'h09;
  localparam logic [7:0] ADDR_CTRL0 = 8'h10;
  localparam logic [7:0] ADDR_CTRL1 = 8'h11;
  localparam logic [7:0] ADDR_PSEL = 8'h12;
  // Control register 0 fields
  localparam int C0_SIM = 0;
  localparam int C0_CLR = 1;
  localparam int C0_CCPY = 2;
  localparam int C0_AINT = 3;
  localparam int C0_EXTD = 4;
  localparam int C0_FRS = 5;
  localparam int C0_MFCS = 6;
  // Control register 1 fields
  localparam int C1_CRC = 0;
  localparam int C1_DFSN = 1;
  localparam int C1_ESEI = 2;
  localparam int C1_ECVE = 3;
  localparam int C1_ECE = 4;
  localparam int C1_OPT = 5;
  localparam int C1_SWD = 6;
  localparam int C1_ASY4 = 7;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [4:0] PSEL_RESET = 5'h00;
  // Timing
  localparam longint CLK_HZ = 25000000;
  localparam longint SCLK_HZ = 4096000;
  localparam longint WIN_US = 250;
  localparam longint WIN_CYC = (WIN_US * CLK_HZ) / 1000000;
  localparam longint NOS_SCLK = 4;
  localparam logic [4:0] NOS_CLK_CYC = 5'((NOS_SCLK * CLK_HZ) / SCLK_HZ);
  // Thresholds and limits
  localparam logic [2:0] LOSS_N3 = 3'h3;
  localparam logic [2:0] LOSS_N4 = 3'h4;
  localparam logic [2:0] ONES_MAX = 3'h3;
  localparam logic [2:0] ZEROS_MAX = 3'h2;
  localparam logic [1:0] MF_GOOD_NEED = 2'h2;
  localparam logic [9:0] CNT_MAX8 = 10'h0FF;
  localparam logic [9:0] CNT_MAX10 = 10'h3FF;
  localparam logic [3:0] FR_MF_START = 4'h0;
  localparam logic [3:0] FR_SI13 = 4'hD;
  localparam logic [3:0] FR_LAST = 4'hF;
  // Loss-of-sync state machine
  typedef enum logic [1:0] {ERA_SYNC, ERA_HUNT, ERA_WAIT_SW, ERA_WAIT_FAS2} era_sync_t;
endpackage : era_pkg
`default_nettype wire

/* rtl/era_rx_alarm.sv */
// Receive alarm detection, sync status, error counters and multiframe flags
//
// The strobed register port was chosen for this implementation.
`default_nettype none
// Operation
// [R1] No-signal: three or fewer ones per window, or route clock missing.
// [R2] Alarm indication: two or fewer zeros per window, cleared when gone.
// [R3] Software ignores no-signal and alarm indication 250 us after resync.
// [R4] Sync lost after 3 or 4 bad alignment or service words, configurable.
// [R5] Resync: good alignment, service word bit 2 set, good alignment again.
// [R6] Multiframe lost with sync; regained after two clean multiframes.
// [R7] Missing route clock also sets sync lost until synchronous and signal back.
// [R8] Simulation forces no-signal, indication, sync lost until released and clear.
// [R9] Remote alarm follows service word bit 3; forced in simulation.
// [R10] Slip flag toggles per slip, and once on simulation start.
// [R11] Slip direction: zero when frame skipped, one when frame repeated.
// [R12] Parity error flag sticky until parity clear; also set in simulation.
// [R13] CRC4 alarm one in doubleframe; set on resync, cleared by two clean MFs.
// [R14] Framing error counter saturates; steps per window in simulation; clear bit.
// [R15] Code violation counter on dual rail; mode bit; steps every four bits in sim.
// [R16] Violation counter extends to ten bits, saturating at 1023.
// [R17] Submultiframe mode counts zero Si bits of frames 13 and 15.
// [R18] CRC error counter per errored submultiframe while synchronous, extendable.
// [R19] Service word reads spare bit, one, remote alarm, five national bits.
// [R20] Transmit multiframe flag set at multiframe start, cleared by write or frame 15.
// [R21] Receive multiframe flag set at start when synchronous, cleared by read or 15.
// [R22] Software polls multiframe flags faster than 2 ms, avoids frame 15.
// [R23] Alarm window counts one 250 us period and restarts after each evaluation.
module era_rx_alarm #(
  parameter longint WIN_CYCLES = era_pkg::WIN_CYC
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Line pins, asynchronous
  input wire logic RX_ROUTE_CLK,
  input wire logic RX_BIT,
  // Receive framer events
  input wire logic FRAME_STB,
  input wire logic [3:0] FRAME_NUM,
  input wire logic FAS_OK,
  input wire logic FAS_ERR,
  input wire logic SW_STB,
  input wire logic [7:0] SW_BYTE,
  input wire logic SMF_STB,
  input wire logic SMF_CRC_BAD,
  // Line decoder, parity and slip events
  input wire logic CODE_VIOL,
  input wire logic CODE_VIOL_EXT,
  input wire logic PAR_ERR,
  input wire logic [4:0] PAR_CHANNEL,
  input wire logic SLIP_NEG,
  input wire logic SLIP_POS,
  // Transmit timing and stack access
  input wire logic TX_FRAME_STB,
  input wire logic [3:0] TX_FRAME_NUM,
  input wire logic TX_STACK_WR,
  input wire logic RX_STACK_RD,
  // Status to neighbours
  output logic IN_SYNC,
  output logic MF_ALIGNED
);
  localparam int WW = $clog2(WIN_CYCLES + 1);
  localparam logic [WW-1:0] WIN_LAST = WW'(WIN_CYCLES - 1);

  if (WIN_CYCLES < 16) begin : g_chk
    $error("WIN_CYCLES too small");
  end

  // Saturating step for 8- or 10-bit counters
  function automatic logic [9:0] sat_inc(input logic [9:0] v, input logic ext);
    logic [9:0] lim;
    lim = ext ? era_pkg::CNT_MAX10 : era_pkg::CNT_MAX8;
    sat_inc = (v >= lim) ? lim : v + 10'h001;
  endfunction : sat_inc

  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [4:0] psel_reg;
  logic frs_pulse;
  logic mfcs_pulse;
  logic ccpy_pulse;
  logic sim;
  logic clr;
  logic crc_en;
  logic dfsn;
  logic crc_mf;
  logic rclk_s1, rclk_s2, rclk_s3;
  logic bit_s1, bit_s2;
  logic rise;
  logic [4:0] gap_cnt;
  logic clk_lost;
  logic [WW-1:0] win_cnt;
  logic win_end;
  logic [2:0] ones_cnt;
  logic [2:0] zeros_cnt;
  logic ones_low;
  logic zeros_low;
  logic [1:0] bit4_cnt;
  era_pkg::era_sync_t sync_reg;
  logic [2:0] fas_run;
  logic [2:0] sw_run;
  logic [2:0] loss_n;
  logic sw_ok;
  logic in_sync;
  logic clk_los_reg;
  logic nos_reg, ais_reg, los_reg;
  logic mf_start, fr15;
  logic mf_sync_reg;
  logic [1:0] mf_good;
  logic mf_err_seen;
  logic rra_rx_reg, rra_force_reg;
  logic remote_alarm_flag;
  logic sim_d;
  logic slp_reg, sdi_reg;
  logic rpe_reg;
  logic clr_d;
  logic clr_fall;
  logic [7:0] fec_reg;
  logic [9:0] cvc_reg;
  logic [9:0] cec_reg;
  logic si_zero;
  logic cv_ev;
  logic cec_ev;
  logic [7:0] sw_reg;
  logic si13_p, si15_p, rs13_reg, rs15_reg;
  logic tx_multiframe_flag_reg, rx_multiframe_flag_reg;
  logic [7:0] rd_mux;

  // Control decode
  assign sim = ctrl0_reg[era_pkg::C0_SIM];
  assign clr = ctrl0_reg[era_pkg::C0_CLR];
  assign crc_en = ctrl1_reg[era_pkg::C1_CRC];
  assign dfsn = ctrl1_reg[era_pkg::C1_DFSN];
  assign crc_mf = crc_en & ~dfsn;

  // Control registers and command pulses
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ctrl0_reg <= era_pkg::CTRL_RESET;
      ctrl1_reg <= era_pkg::CTRL_RESET;
      psel_reg <= era_pkg::PSEL_RESET;
    end else if (WR) begin
      if (ADDR == era_pkg::ADDR_CTRL0) ctrl0_reg <= WDATA;
      if (ADDR == era_pkg::ADDR_CTRL1) ctrl1_reg <= WDATA;
      if (ADDR == era_pkg::ADDR_PSEL) psel_reg <= WDATA[4:0];
    end
  end
  assign frs_pulse = WR && ADDR == era_pkg::ADDR_CTRL0 && WDATA[era_pkg::C0_FRS];
  assign mfcs_pulse = WR && ADDR == era_pkg::ADDR_CTRL0 && WDATA[era_pkg::C0_MFCS];
  assign ccpy_pulse = WR && ADDR == era_pkg::ADDR_CTRL0 && WDATA[era_pkg::C0_CCPY];

  // Pin synchronisers and route clock edge
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rclk_s1 <= 1'b0;
      rclk_s2 <= 1'b0;
      rclk_s3 <= 1'b0;
      bit_s1 <= 1'b0;
      bit_s2 <= 1'b0;
    end else begin
      rclk_s1 <= RX_ROUTE_CLK;
      rclk_s2 <= rclk_s1;
      rclk_s3 <= rclk_s2;
      bit_s1 <= RX_BIT;
      bit_s2 <= bit_s1;
    end
  end
  assign rise = rclk_s2 & ~rclk_s3;

  // Route clock gap watchdog
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      gap_cnt <= 5'h00;
    end else if (rise) begin
      gap_cnt <= 5'h00;
    end else if (gap_cnt < era_pkg::NOS_CLK_CYC) begin
      gap_cnt <= gap_cnt + 5'h01;
    end
  end
  assign clk_lost = gap_cnt >= era_pkg::NOS_CLK_CYC; // [R1]

  // Observation window, restarted after each evaluation
  always_ff @(posedge CLOCK) begin
    if (!RST_N) win_cnt <= '0;
    else win_cnt <= win_end ? '0 : win_cnt + 1'b1; // [R23]
  end
  assign win_end = win_cnt == WIN_LAST;

  // Ones and zeros per window, saturating
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ones_cnt <= 3'h0;
      zeros_cnt <= 3'h0;
      ones_low <= 1'b0;
      zeros_low <= 1'b0;
    end else if (win_end) begin
      ones_low <= ones_cnt <= era_pkg::ONES_MAX; // [R1]
      zeros_low <= zeros_cnt <= era_pkg::ZEROS_MAX; // [R2]
      ones_cnt <= {2'b00, rise & bit_s2};
      zeros_cnt <= {2'b00, rise & ~bit_s2};
    end else if (rise) begin
      if (bit_s2 && !ones_cnt[2]) ones_cnt <= ones_cnt + 3'h1;
      if (!bit_s2 && !zeros_cnt[2]) zeros_cnt <= zeros_cnt + 3'h1;
    end
  end

  // Received bit counter for simulated violations
  always_ff @(posedge CLOCK) begin
    if (!RST_N) bit4_cnt <= 2'h0;
    else if (rise) bit4_cnt <= bit4_cnt + 2'h1;
  end

  // Loss and regain of pulseframe synchronisation
  assign loss_n = ctrl1_reg[era_pkg::C1_ASY4] ? era_pkg::LOSS_N4 : era_pkg::LOSS_N3;
  assign sw_ok = SW_BYTE[6];
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sync_reg <= era_pkg::ERA_HUNT;
      fas_run <= 3'h0;
      sw_run <= 3'h0;
    end else if (frs_pulse) begin
      sync_reg <= era_pkg::ERA_HUNT;
      fas_run <= 3'h0;
      sw_run <= 3'h0;
    end else begin
      unique case (sync_reg)
        era_pkg::ERA_SYNC: begin
          if (FAS_ERR) fas_run <= fas_run + 3'h1;
          else if (FAS_OK) fas_run <= 3'h0;
          if (SW_STB && !ctrl1_reg[era_pkg::C1_SWD]) begin
            sw_run <= sw_ok ? 3'h0 : sw_run + 3'h1;
          end
          if ((FAS_ERR && fas_run + 3'h1 >= loss_n) ||
              (SW_STB && !sw_ok && !ctrl1_reg[era_pkg::C1_SWD] &&
               sw_run + 3'h1 >= loss_n)) begin
            sync_reg <= era_pkg::ERA_HUNT; // [R4]
            fas_run <= 3'h0;
            sw_run <= 3'h0;
          end
        end
        era_pkg::ERA_HUNT: begin
          if (FAS_OK) sync_reg <= era_pkg::ERA_WAIT_SW; // [R5]
        end
        era_pkg::ERA_WAIT_SW: begin
          if (SW_STB) sync_reg <= sw_ok ? era_pkg::ERA_WAIT_FAS2 : era_pkg::ERA_HUNT; // [R5]
        end
        era_pkg::ERA_WAIT_FAS2: begin
          if (FAS_OK) sync_reg <= era_pkg::ERA_SYNC; // [R5]
          else if (FAS_ERR) sync_reg <= era_pkg::ERA_HUNT;
        end
      endcase
    end
  end
  assign in_sync = sync_reg == era_pkg::ERA_SYNC;

  // Route clock loss latch
  always_ff @(posedge CLOCK) begin
    if (!RST_N) clk_los_reg <= 1'b0;
    else if (clk_lost) clk_los_reg <= 1'b1; // [R7]
    else if (in_sync && !ones_low) clk_los_reg <= 1'b0; // [R7]
  end

  // Alarm flags, forced while simulating
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      nos_reg <= 1'b0;
      ais_reg <= 1'b0;
      los_reg <= 1'b1;
    end else begin
      nos_reg <= sim | ones_low | clk_lost; // [R1] [R8]
      ais_reg <= sim | zeros_low; // [R2] [R8]
      los_reg <= sim | ~in_sync | clk_los_reg; // [R7] [R8]
    end
  end

  // Multiframe alignment
  assign mf_start = FRAME_STB && FRAME_NUM == era_pkg::FR_MF_START;
  assign fr15 = FRAME_STB && FRAME_NUM == era_pkg::FR_LAST;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      mf_sync_reg <= 1'b0;
      mf_good <= 2'h0;
      mf_err_seen <= 1'b0;
    end else if (!in_sync || frs_pulse || mfcs_pulse) begin
      mf_sync_reg <= 1'b0; // [R6] [R13]
      mf_good <= 2'h0;
      mf_err_seen <= 1'b0;
    end else if (mf_start) begin
      mf_err_seen <= 1'b0;
      if (mf_err_seen) begin
        mf_good <= 2'h0;
      end else if (mf_good != era_pkg::MF_GOOD_NEED) begin
        mf_good <= mf_good + 2'h1;
        if (mf_good + 2'h1 == era_pkg::MF_GOOD_NEED) mf_sync_reg <= 1'b1; // [R6]
      end
    end else if (FAS_ERR) begin
      mf_err_seen <= 1'b1;
    end
  end

  // Remote alarm, forced while simulating
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rra_rx_reg <= 1'b0;
      rra_force_reg <= 1'b0;
    end else begin
      if (SW_STB) rra_rx_reg <= SW_BYTE[5]; // [R9]
      if (sim) rra_force_reg <= 1'b1; // [R9]
      else if (!ctrl0_reg[era_pkg::C0_AINT]) rra_force_reg <= 1'b0;
    end
  end
  assign remote_alarm_flag = rra_rx_reg | rra_force_reg;

  // Slip toggle and direction
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sim_d <= 1'b0;
      slp_reg <= 1'b0;
      sdi_reg <= 1'b0;
    end else begin
      sim_d <= sim;
      if (SLIP_NEG || SLIP_POS || (sim && !sim_d)) slp_reg <= ~slp_reg; // [R10]
      if (SLIP_NEG || SLIP_POS) sdi_reg <= SLIP_POS; // [R11]
    end
  end

  // Sticky parity error; a new error wins over the clear
  always_ff @(posedge CLOCK) begin
    if (!RST_N) rpe_reg <= 1'b0;
    else if ((PAR_ERR && PAR_CHANNEL == psel_reg) || sim) rpe_reg <= 1'b1; // [R12]
    else if (ccpy_pulse) rpe_reg <= 1'b0; // [R12]
  end

  // Counter clear release detection
  always_ff @(posedge CLOCK) begin
    if (!RST_N) clr_d <= 1'b0;
    else clr_d <= clr;
  end
  assign clr_fall = clr_d & ~clr;

  // Framing error counter
  always_ff @(posedge CLOCK) begin
    if (!RST_N) fec_reg <= 8'h00;
    else if (clr_fall) fec_reg <= 8'h00; // [R14]
    else if (!clr && (sim ? win_end : (FAS_ERR && in_sync))) begin
      fec_reg <= 8'(sat_inc({2'b00, fec_reg}, 1'b0)); // [R14]
    end
  end

  // Violation counter source selection
  assign si_zero = SW_STB && !SW_BYTE[7] &&
                   (FRAME_NUM == era_pkg::FR_SI13 || FRAME_NUM == era_pkg::FR_LAST);
  always_comb begin
    if (sim) cv_ev = rise && bit4_cnt == 2'h3; // [R15]
    else if (ctrl1_reg[era_pkg::C1_ESEI]) cv_ev = crc_mf & si_zero; // [R17]
    else if (ctrl1_reg[era_pkg::C1_OPT]) cv_ev = 1'b0; // [R15]
    else cv_ev = ctrl0_reg[era_pkg::C0_EXTD] ? CODE_VIOL_EXT : CODE_VIOL; // [R15]
  end
  assign cec_ev = crc_mf & SMF_STB & (sim | (SMF_CRC_BAD & in_sync)); // [R18]

  // Violation and CRC error counters
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      cvc_reg <= 10'h000;
      cec_reg <= 10'h000;
    end else if (clr_fall) begin
      cvc_reg <= 10'h000;
      cec_reg <= 10'h000;
    end else if (!clr) begin
      if (cv_ev) cvc_reg <= sat_inc(cvc_reg, ctrl1_reg[era_pkg::C1_ECVE]); // [R16]
      if (cec_ev) cec_reg <= sat_inc(cec_reg, ctrl1_reg[era_pkg::C1_ECE]); // [R18]
    end
  end

  // Service word and spare bits of frames 13 and 15
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sw_reg <= 8'h00;
      si13_p <= 1'b0;
      si15_p <= 1'b0;
      rs13_reg <= 1'b0;
      rs15_reg <= 1'b0;
    end else begin
      if (SW_STB) sw_reg <= SW_BYTE;
      if (SW_STB && FRAME_NUM == era_pkg::FR_SI13) si13_p <= SW_BYTE[7];
      if (SW_STB && FRAME_NUM == era_pkg::FR_LAST) si15_p <= SW_BYTE[7];
      if (mf_start && crc_mf) begin
        rs13_reg <= si13_p; // [R21]
        rs15_reg <= si15_p;
      end else if (!crc_mf) begin
        rs13_reg <= 1'b0;
        rs15_reg <= 1'b0;
      end
    end
  end

  // Multiframe flags; held clear with CRC off, otherwise setting wins over clearing
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      tx_multiframe_flag_reg <= 1'b0;
      rx_multiframe_flag_reg <= 1'b0;
    end else begin
      if (!crc_en) tx_multiframe_flag_reg <= 1'b0;
      else if (TX_FRAME_STB && TX_FRAME_NUM == era_pkg::FR_MF_START) tx_multiframe_flag_reg <= 1'b1; // [R20]
      else if (TX_STACK_WR || (TX_FRAME_STB && TX_FRAME_NUM == era_pkg::FR_LAST && !dfsn)) begin
        tx_multiframe_flag_reg <= 1'b0; // [R20]
      end
      if (!crc_en) rx_multiframe_flag_reg <= 1'b0;
      else if (mf_start && (dfsn ? in_sync : mf_sync_reg)) rx_multiframe_flag_reg <= 1'b1; // [R21]
      else if (RX_STACK_RD || (fr15 && !dfsn)) rx_multiframe_flag_reg <= 1'b0; // [R21]
    end
  end

  // Read multiplexer
  always_comb begin
    unique case (ADDR)
      era_pkg::ADDR_RSR: rd_mux = {nos_reg, ais_reg, los_reg, remote_alarm_flag, slp_reg, rpe_reg,
                                   ~crc_mf | ~mf_sync_reg, sdi_reg}; // [R13]
      era_pkg::ADDR_FEC: rd_mux = fec_reg;
      era_pkg::ADDR_CVC: rd_mux = cvc_reg[7:0];
      era_pkg::ADDR_CEC: rd_mux = cec_reg[7:0];
      era_pkg::ADDR_RSW: rd_mux = {crc_en | sw_reg[7], 1'b1, remote_alarm_flag, sw_reg[4:0]}; // [R19]
      era_pkg::ADDR_RSP: rd_mux = {tx_multiframe_flag_reg, rx_multiframe_flag_reg, 4'h0, rs13_reg, rs15_reg};
      era_pkg::ADDR_CNTX: rd_mux = {4'h0, cec_reg[9:8], cvc_reg[9:8]};
      era_pkg::ADDR_CTRL0: rd_mux = {1'b0, 1'b0, 1'b0, ctrl0_reg[4:3], 1'b0, ctrl0_reg[1:0]};
      era_pkg::ADDR_CTRL1: rd_mux = ctrl1_reg;
      era_pkg::ADDR_PSEL: rd_mux = {3'h0, psel_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data one cycle after strobe
  always_ff @(posedge CLOCK) begin
    if (!RST_N) RDATA <= 8'h00;
    else RDATA <= RD ? rd_mux : 8'h00;
  end

  assign IN_SYNC = in_sync;
  assign MF_ALIGNED = mf_sync_reg;
endmodule : era_rx_alarm
`default_nettype wire

/* tb/era_line_model.sv */
// Far-end line: route clock and data bits from a remote transmitter
`default_nettype none
module era_line_model (
  // Control from the bench
  input wire logic run,
  input wire logic [1:0] pat,
  // Line pins
  output logic route_clk,
  output logic rx_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bits change after the falling edge
  initial begin
    route_clk = 1'b0;
    rx_bit = 1'b0;
    #7;
    forever begin
      if (run) begin
        #160 route_clk = 1'b1;
        #160 route_clk = 1'b0;
        rx_bit = (pat == 2'd1) ? 1'b1 : (pat == 2'd2) ? 1'b0 : ~rx_bit;
      end else begin
        #160 rx_bit = ~rx_bit;
      end
    end
  end
endmodule : era_line_model
`default_nettype wire

/* tb/era_rx_alarm_asserts.sv */
// Port-level checker for the receive alarm and status block
`default_nettype none
module era_rx_alarm_asserts (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // Framer events and status
  input wire logic FRAME_STB,
  input wire logic [3:0] FRAME_NUM,
  input wire logic FAS_OK,
  input wire logic IN_SYNC,
  input wire logic MF_ALIGNED
);
  logic sim_reg;
  logic [1:0] ctrl1_reg;
  logic crc_mf;
  logic rd_rsr;
  // Control bit shadow
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sim_reg <= 1'b0;
      ctrl1_reg <= 2'b00;
    end else if (WR && ADDR == era_pkg::ADDR_CTRL0) begin
      sim_reg <= WDATA[era_pkg::C0_SIM];
    end else if (WR && ADDR == era_pkg::ADDR_CTRL1) begin
      ctrl1_reg <= WDATA[1:0];
    end
  end
  // Mode and read decode
  assign crc_mf = ctrl1_reg[0] && !ctrl1_reg[1];
  assign rd_rsr = RD && ADDR == era_pkg::ADDR_RSR;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not idle");
  a_sync_rise: assert property ($rose(IN_SYNC) |-> $past(FAS_OK))
    else $error("sync without alignment");
  a_mf_rise: assert property ($rose(MF_ALIGNED) |->
    $past(FRAME_STB) && $past(FRAME_NUM) == 4'h0 && $past(IN_SYNC))
    else $error("bad multiframe align");
  a_mf_follows: assert property (!IN_SYNC |=> !MF_ALIGNED)
    else $error("multiframe kept");
  a_force_hunt: assert property (WR && ADDR == era_pkg::ADDR_CTRL0 &&
    WDATA[era_pkg::C0_FRS] |=> !IN_SYNC)
    else $error("resync not forced");
  a_lost_shown: assert property (rd_rsr && !IN_SYNC && !$past(IN_SYNC) |=> RDATA[5])
    else $error("sync lost low");
  a_sim_forces: assert property (rd_rsr && sim_reg && $past(sim_reg) &&
    $past(sim_reg, 2) |=> RDATA[7:5] == 3'b111)
    else $error("alarms not forced");
  a_word_one: assert property (RD && ADDR == era_pkg::ADDR_RSW |=> RDATA[6])
    else $error("word bit 6 low");
  a_crc_alarm: assert property (rd_rsr && $stable(MF_ALIGNED) && !$past(WR) |=>
    RDATA[1] == !($past(crc_mf) && $past(MF_ALIGNED)))
    else $error("crc4 alarm bit wrong");
  c_sync: cover property ($rose(IN_SYNC));
  c_mf: cover property ($rose(MF_ALIGNED));
  c_sim: cover property (rd_rsr && sim_reg);
endmodule : era_rx_alarm_asserts
bind era_rx_alarm era_rx_alarm_asserts u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FRAME_STB(FRAME_STB),
  .FRAME_NUM(FRAME_NUM), .FAS_OK(FAS_OK), .IN_SYNC(IN_SYNC), .MF_ALIGNED(MF_ALIGNED));
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the receive alarm and status block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN = 128;
  logic clk, rst_n, wr, rd, route_clk, rx_bit, line_run, in_sync, mf_aligned;
  logic [7:0] addr, wdata, rdata, sw_byte, d;
  logic fas_ok, fas_err, sw_stb, frame_stb, smf_stb, smf_bad, code_viol, cv_ext;
  logic par_err, slip_neg, slip_pos, tx_frame_stb, tx_stack_wr, rx_stack_rd;
  logic [3:0] frame_num, tx_frame_num;
  logic [4:0] par_ch;
  logic [1:0] line_pat;
  int n_errors, comparisons, cycles;
  era_rx_alarm #(.WIN_CYCLES(WIN)) uut (.CLOCK(clk), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX_ROUTE_CLK(route_clk),
    .RX_BIT(rx_bit), .FRAME_STB(frame_stb), .FRAME_NUM(frame_num), .FAS_OK(fas_ok),
    .FAS_ERR(fas_err), .SW_STB(sw_stb), .SW_BYTE(sw_byte), .SMF_STB(smf_stb),
    .SMF_CRC_BAD(smf_bad), .CODE_VIOL(code_viol), .CODE_VIOL_EXT(cv_ext),
    .PAR_ERR(par_err), .PAR_CHANNEL(par_ch), .SLIP_NEG(slip_neg), .SLIP_POS(slip_pos),
    .TX_FRAME_STB(tx_frame_stb), .TX_FRAME_NUM(tx_frame_num), .TX_STACK_WR(tx_stack_wr),
    .RX_STACK_RD(rx_stack_rd), .IN_SYNC(in_sync), .MF_ALIGNED(mf_aligned));
  era_line_model u_line (.run(line_run), .pat(line_pat), .route_clk(route_clk),
    .rx_bit(rx_bit));
  // System clock, 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 45000) begin
      n_errors++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  // Read data stand one cycle
  task rd_reg(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask : rd_reg
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    rd_reg(a);
    chk(d, exp);
  endtask : rchk
  task st(input logic [1:0] exp);
    @(negedge clk);
    chk({in_sync, mf_aligned}, exp);
    @(posedge clk);
  endtask : st
  // One-cycle framer, line, slip, parity or stack event by index k
  task ev(input int k, input logic [7:0] v);
    case (k)
      0: fas_ok <= 1'b1;
      1: fas_err <= 1'b1;
      2: begin sw_stb <= 1'b1; sw_byte <= v; end
      3: begin frame_stb <= 1'b1; frame_num <= v[3:0]; end
      4: begin smf_stb <= 1'b1; smf_bad <= v[0]; end
      5: code_viol <= 1'b1;
      6: slip_neg <= 1'b1;
      7: slip_pos <= 1'b1;
      8: begin par_err <= 1'b1; par_ch <= v[4:0]; end
      9: cv_ext <= 1'b1;
      10: begin tx_frame_stb <= 1'b1; tx_frame_num <= v[3:0]; end
      11: tx_stack_wr <= 1'b1;
      default: rx_stack_rd <= 1'b1;
    endcase
    @(posedge clk);
    {fas_ok, fas_err, sw_stb, frame_stb, smf_stb, code_viol, cv_ext, slip_neg, slip_pos,
      par_err, tx_frame_stb, tx_stack_wr, rx_stack_rd} <= '0;
    @(posedge clk);
  endtask : ev
  task sync_up;
    ev(0, 8'h00);
    ev(2, 8'h40);
    ev(0, 8'h00);
  endtask : sync_up
  // Main sequence
  initial begin
    {rst_n, wr, rd, fas_ok, fas_err, sw_stb, frame_stb, smf_stb, smf_bad, code_viol} = '0;
    {cv_ext, par_err, slip_neg, slip_pos, tx_frame_stb, tx_stack_wr, rx_stack_rd} = '0;
    {addr, wdata, sw_byte, frame_num, tx_frame_num, par_ch, line_pat} = '0;
    line_run = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(era_pkg::ADDR_RSR, 8'h22);
    rchk(era_pkg::ADDR_RSW, 8'h40);
    rchk(8'h07, 8'h00);
    // Broken resync sequences stay hunting
    ev(0, 8'h00);
    ev(2, 8'h00);
    st(2'b00);
    ev(0, 8'h00);
    ev(2, 8'h40);
    ev(1, 8'h00);
    st(2'b00);
    sync_up();
    st(2'b10);
    rchk(era_pkg::ADDR_RSR, 8'h02);
    ev(2, 8'h7F);
    rchk(era_pkg::ADDR_RSW, 8'h7F);
    rchk(era_pkg::ADDR_RSR, 8'h12);
    ev(2, 8'h40);
    rchk(era_pkg::ADDR_RSR, 8'h02);
    // Loss after three, then four, bad alignment words
    for (int n = 3; n <= 4; n++) begin
      wr_reg(era_pkg::ADDR_CTRL1, (n == 4) ? 8'h80 : 8'h00);
      sync_up();
      repeat (n - 1) ev(1, 8'h00);
      st(2'b10);
      ev(1, 8'h00);
      st(2'b00);
    end
    rchk(era_pkg::ADDR_FEC, 8'h07);
    // Bad service words, checked then ignored
    for (int s = 0; s < 2; s++) begin
      wr_reg(era_pkg::ADDR_CTRL1, s ? 8'h40 : 8'h00);
      sync_up();
      repeat (3) ev(2, 8'h00);
      st(s ? 2'b10 : 2'b00);
    end
    wr_reg(era_pkg::ADDR_CTRL1, 8'h00);
    sync_up();
    // All ones, all zeros, stopped clock
    line_pat <= 2'd1;
    repeat (3 * WIN) @(posedge clk);
    rd_reg(era_pkg::ADDR_RSR);
    chk(d[7:5], 3'b010);
    line_pat <= 2'd2;
    repeat (3 * WIN) @(posedge clk);
    rd_reg(era_pkg::ADDR_RSR);
    chk(d[7:5], 3'b100);
    line_pat <= 2'd0;
    line_run <= 1'b0;
    repeat (40) @(posedge clk);
    rd_reg(era_pkg::ADDR_RSR);
    chk({d[7], d[5]}, 2'b11);
    line_run <= 1'b1;
    repeat (3 * WIN) @(posedge clk);
    rd_reg(era_pkg::ADDR_RSR);
    chk(d[7:5], 3'b000);
    st(2'b10);
    // CRC multiframe, flags, errors, resync
    wr_reg(era_pkg::ADDR_CTRL1, 8'h01);
    repeat (3) ev(3, 8'h00);
    st(2'b11);
    rd_reg(era_pkg::ADDR_RSR);
    chk(d[1], 1'b0);
    rd_reg(era_pkg::ADDR_RSP);
    chk(d[6], 1'b1);
    ev(12, 8'h00);
    rd_reg(era_pkg::ADDR_RSP);
    chk(d[6], 1'b0);
    ev(10, 8'h00);
    rd_reg(era_pkg::ADDR_RSP);
    chk(d[7], 1'b1);
    ev(10, 8'h0F);
    rd_reg(era_pkg::ADDR_RSP);
    chk(d[7], 1'b0);
    ev(4, 8'h01);
    ev(4, 8'h00);
    ev(4, 8'h01);
    rchk(era_pkg::ADDR_CEC, 8'h02);
    wr_reg(era_pkg::ADDR_CTRL0, 8'h20);
    st(2'b00);
    rd_reg(era_pkg::ADDR_RSR);
    chk(d[1], 1'b1);
    // Code violations in both detection modes
    wr_reg(era_pkg::ADDR_CTRL1, 8'h00);
    ev(5, 8'h00);
    ev(9, 8'h00);
    rchk(era_pkg::ADDR_CVC, 8'h01);
    wr_reg(era_pkg::ADDR_CTRL0, 8'h10);
    ev(5, 8'h00);
    ev(9, 8'h00);
    rchk(era_pkg::ADDR_CVC, 8'h02);
    // Slips toggle the flag and set the direction
    ev(6, 8'h00);
    rd_reg(era_pkg::ADDR_RSR);
    chk({d[3], d[0]}, 2'b10);
    ev(7, 8'h00);
    rd_reg(era_pkg::ADDR_RSR);
    chk({d[3], d[0]}, 2'b01);
    // Parity on other and selected channel
    wr_reg(era_pkg::ADDR_PSEL, 8'h05);
    ev(8, 8'h03);
    rd_reg(era_pkg::ADDR_RSR);
    chk(d[2], 1'b0);
    ev(8, 8'h05);
    rd_reg(era_pkg::ADDR_RSR);
    chk(d[2], 1'b1);
    wr_reg(era_pkg::ADDR_CTRL0, 8'h04);
    rd_reg(era_pkg::ADDR_RSR);
    chk(d[2], 1'b0);
    // Alarm simulation until counters saturate
    wr_reg(era_pkg::ADDR_CTRL1, 8'h08);
    wr_reg(era_pkg::ADDR_CTRL0, 8'h01);
    repeat (270 * WIN) @(posedge clk);
    rd_reg(era_pkg::ADDR_RSR);
    chk(d[7:2], 6'h3F);
    rchk(era_pkg::ADDR_FEC, 8'hFF);
    rchk(era_pkg::ADDR_CVC, 8'hFF);
    rd_reg(era_pkg::ADDR_CNTX);
    chk(d[1:0], 2'b11);
    wr_reg(era_pkg::ADDR_CTRL0, 8'h03);
    wr_reg(era_pkg::ADDR_CTRL0, 8'h00);
    repeat (3 * WIN) @(posedge clk);
    rchk(era_pkg::ADDR_FEC, 8'h00);
    rchk(era_pkg::ADDR_RSR, 8'h2F);
    wr_reg(era_pkg::ADDR_CTRL0, 8'h04);
    rchk(era_pkg::ADDR_RSR, 8'h2B);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
